// ===== ast_pkg.sv
package ast_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_FLAGS      = 8'h10;
    localparam logic [7:0] IDX_IRQ_EN     = 8'h11;
    localparam logic [7:0] IDX_RX_CTRL    = 8'h13;
    localparam logic [7:0] IDX_RX_FIFO    = 8'h14;
    localparam logic [7:0] IDX_TX_CTRL    = 8'h15;
    localparam logic [7:0] IDX_TX_HOLD    = 8'h16;
    localparam logic [7:0] IDX_BAUD_DIV   = 8'h17;
    // Transmit control/status fields
    localparam int TX_CLK_SRC_BIT  = 7;
    localparam int TX_NINE_BIT     = 6;
    localparam int TX_EN_BIT       = 5;
    localparam int TX_SYNC_BIT     = 4;
    localparam int TX_EMPTY_BIT    = 1;
    localparam int TX_D8_BIT       = 0;
    // Receive control/status fields
    localparam int RX_SERIAL_PORT_ENABLE_BIT     = 7;
    localparam int RX_NINE_BIT     = 6;
    localparam int RX_SINGLE_BIT   = 5;
    localparam int RX_CONT_BIT     = 4;
    localparam int RX_FRAMING_ERROR_BIT_BIT     = 2;
    localparam int RX_OVERRUN_ERROR_BIT_BIT     = 1;
    localparam int RX_D8_BIT       = 0;
    // Flag register fields
    localparam int FLAG_TX_BIT     = 1;
    localparam int FLAG_RX_BIT     = 0;
    // Reset values
    localparam logic [7:0] FLAGS_RST    = 8'h02;
    localparam logic [7:0] IRQ_EN_RST   = 8'h00;
    localparam logic [7:0] BAUD_DIV_RST = 8'h00;
    // Oversampling: x16 clock, votes on 7th, 8th and 9th edges
    localparam logic [3:0] PHASE_LAST   = 4'hf;
    localparam logic [3:0] SAMPLE_A     = 4'h6;
    localparam logic [3:0] SAMPLE_B     = 4'h7;
    localparam logic [3:0] SAMPLE_C     = 4'h8;
    localparam logic [3:0] BITS_EIGHT   = 4'h9;
    localparam logic [3:0] BITS_NINE    = 4'ha;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP}
        ast_rx_state_t;
endpackage : ast_pkg

// ===== ast_remote.sv
`timescale 1ns/1ps
module ast_remote #(
    parameter int BIT_CLKS = 16
) (
    // Line side
    input  wire logic hclk,
    input  wire logic line_in,
    output logic      line_out
);
    logic [8:0] got[$];
    logic       nine = 1'b0;
    logic [8:0] w;

    initial line_out = 1'b1;

    // Start low, data LSB first, then stop; bad stop only on request
    task automatic send(input logic [8:0] d, input logic stop_ok);
        for (int i = -1; i <= (nine ? 9 : 8); i++) begin
            line_out <= (i < 0) ? 1'b0 :
                        (i == (nine ? 9 : 8)) ? stop_ok : d[i];
            repeat (BIT_CLKS) @(posedge hclk);
        end
        line_out <= 1'b1;
        repeat (BIT_CLKS) @(posedge hclk);
    endtask : send

    // One-clock low pulse on an idle line; must not pass as a start bit
    task automatic glitch();
        line_out <= 1'b0;
        @(posedge hclk);
        line_out <= 1'b1;
    endtask : glitch

    // Mid-bit sampling; a word with a low stop bit is not kept
    always begin
        @(negedge line_in);
        repeat (BIT_CLKS / 2) @(posedge hclk);
        if (line_in === 1'b0) begin
            w = '0;
            for (int i = 0; i < (nine ? 9 : 8); i++) begin
                repeat (BIT_CLKS) @(posedge hclk);
                w[i] = line_in;
            end
            repeat (BIT_CLKS) @(posedge hclk);
            if (line_in === 1'b1) got.push_back(w);
        end
    end
endmodule : ast_remote

// ===== ast_uart.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: Shifter reloads only after the previous stop bit has gone out.
// R2: Holding-to-shifter move at baud tick; holding empties, transmit flag sets.
// R3: Transmit flag not writable; cleared only by a holding buffer write.
// R4: Transmit status bit 1 reads shifter empty; no interrupt attached.
// R5: Frame starts only with data waiting, enable set and a shift tick.
// R6: Setting enable after loading the holding buffer starts that data.
// R7: Write to idle shifter passes straight through; back-to-back frames.
// R8: Clearing transmit enable aborts frame, resets transmitter, floats pin.
// R9: Software writes ninth bit and select before the data byte.
// R10: Recovery runs at sixteen times baud; shifter moves at bit rate.
// R11: Asynchronous reception only while continuous receive enable is set.
// R12: After stop bit, word enters FIFO if room; receive flag then sets.
// R13: Receive flag read-only; clears when FIFO read empty.
// R14: Two-entry FIFO plus shifter; reads return the oldest word.
// R15: Stop bit with FIFO full sets overrun and drops the word.
// R16: Overrun blocks transfers; cleared by resetting receive via enable.
// R17: Framing error set when a valid stop bit is missing.
// R18: Framing error and ninth bit travel with each word in FIFO.
// R19: Each bit decided by majority of three samples, phases 7-9.
// R20: Asynchronous mode when sync clear and port enable set.
// R21: Receive logic resets when both enables or port enable clear.
// R22: Sync bit selects synchronous mode; port enable claims pins, but tx_pin_oe also needs transmit enable or the sync clock source.
// R23: Sync master is half duplex; drives clock pin when source set.
// R24: Frame: start, eight or nine data bits, one stop, NRZ.
// R25: Idle high, start low, stop high, data LSB first.
// R26: Start is a falling edge confirmed low; sample phase aligns.
module ast_uart #(
    parameter int FIFO_DEPTH = 2
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Serial pins
    input  wire logic        rx_pin_in,
    output logic             tx_pin_out,
    output logic             tx_pin_oe
);
    // Bus front end
    logic [7:0]  addr_reg;
    logic        wr_reg;
    logic        rd_ok_reg;
    logic [31:0] hrdata_reg;
    // Software registers
    logic [7:0]  baud_div_reg;
    logic [7:0]  irq_en_reg;
    logic [7:0]  tx_ctrl_reg;
    logic [7:0]  rx_ctrl_reg;
    logic [7:0]  tx_hold_reg;
    logic        hold_full_reg;
    // Baud generator
    logic [7:0]  brg_cnt_reg;
    logic [3:0]  tx_phase_reg;
    // Transmitter
    logic        tx_busy_reg;
    logic [9:0]  tx_shift_reg;
    logic [3:0]  tx_left_reg;
    logic        tx_out_reg;
    logic        tx_oe_reg;
    // Receiver
    logic [1:0]  rx_sync_reg;
    logic        rx_prev_reg;
    ast_pkg::ast_rx_state_t rx_state_reg;
    logic [3:0]  rx_phase_reg;
    logic [2:0]  rx_votes_reg;
    logic [8:0]  rx_shift_reg;
    logic [3:0]  rx_cnt_reg;
    logic        overrun_error_bit_reg;
    logic [9:0]  fifo_mem [FIFO_DEPTH];
    logic        fifo_rd_reg;
    logic        fifo_wr_reg;
    logic [1:0]  fifo_cnt_reg;

    function automatic logic majority(input logic [2:0] v);
        majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction : majority

    function automatic logic [3:0] frame_bits(input logic nine);
        frame_bits = nine ? ast_pkg::BITS_NINE : ast_pkg::BITS_EIGHT;
    endfunction : frame_bits

    // Bus decode
    wire        addr_phase = hsel & hready & htrans[1];
    wire [7:0]  addr_idx   = haddr[9:2];
    wire        wr_en      = wr_reg;
    wire [7:0]  wdata      = hwdata[7:0];
    wire        wr_tx_hold = wr_en & (addr_reg == ast_pkg::IDX_TX_HOLD);
    wire        wr_tx_ctrl = wr_en & (addr_reg == ast_pkg::IDX_TX_CTRL);
    wire        wr_rx_ctrl = wr_en & (addr_reg == ast_pkg::IDX_RX_CTRL);
    wire        wr_baud    = wr_en & (addr_reg == ast_pkg::IDX_BAUD_DIV);
    wire        wr_irq_en  = wr_en & (addr_reg == ast_pkg::IDX_IRQ_EN);
    wire        rd_fifo    = addr_phase & ~hwrite &
                             (addr_idx == ast_pkg::IDX_RX_FIFO);
    // Mode decode
    wire serial_port_enable      = rx_ctrl_reg[ast_pkg::RX_SERIAL_PORT_ENABLE_BIT];
    wire sync_mode = tx_ctrl_reg[ast_pkg::TX_SYNC_BIT];
    wire async_on  = serial_port_enable & ~sync_mode;                      // [R20]
    wire tx_en     = async_on & tx_ctrl_reg[ast_pkg::TX_EN_BIT];
    wire rx_en     = async_on & rx_ctrl_reg[ast_pkg::RX_CONT_BIT]; // [R11]
    wire rx_reset  = ~serial_port_enable | ~(rx_ctrl_reg[ast_pkg::RX_CONT_BIT] |
                     rx_ctrl_reg[ast_pkg::RX_SINGLE_BIT]);   // [R21]
    wire sync_clk_drive = serial_port_enable & sync_mode &
                          tx_ctrl_reg[ast_pkg::TX_CLK_SRC_BIT]; // [R22] [R23]
    wire tx_empty  = ~tx_busy_reg;                           // [R4]
    wire tx_flag   = ~hold_full_reg;                         // [R3]
    wire rx_flag   = fifo_cnt_reg != 2'h0;                   // [R13]
    wire [9:0] fifo_head = fifo_mem[fifo_rd_reg];

    // Baud generator: one x16 tick per divisor+1 clocks
    wire x16_tick = brg_cnt_reg == 8'h00;
    wire tx_tick  = x16_tick & (tx_phase_reg == ast_pkg::PHASE_LAST); // [R10]
    wire tx_load  = tx_en & hold_full_reg & tx_tick &
                    (tx_empty | tx_left_reg == 4'h0);        // [R1] [R5]

    // Receiver decode
    wire rx_bit     = rx_sync_reg[1];
    wire rx_vote_at = x16_tick & (rx_phase_reg == ast_pkg::SAMPLE_C);
    wire rx_level   = majority({rx_votes_reg[1:0], rx_bit}); // [R19]
    wire rx_fall    = rx_prev_reg & ~rx_bit;
    wire rx_stop_at = rx_vote_at & (rx_state_reg == ast_pkg::RX_STOP);
    wire fifo_full  = fifo_cnt_reg == 2'(FIFO_DEPTH);
    wire fifo_push  = rx_stop_at & ~fifo_full & ~overrun_error_bit_reg;   // [R12] [R16]
    wire fifo_pop   = rd_fifo & rx_flag;
    wire [9:0] rx_word = rx_ctrl_reg[ast_pkg::RX_NINE_BIT] ?
                         {~rx_level, rx_shift_reg} :
                         {~rx_level, 1'b0, rx_shift_reg[8:1]}; // [R17] [R18]

    // Read mux, sampled in the address phase so hrdata is a flop
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        unique case (addr_idx)
            ast_pkg::IDX_FLAGS: begin
                rd_mux[ast_pkg::FLAG_TX_BIT] = tx_flag;
                rd_mux[ast_pkg::FLAG_RX_BIT] = rx_flag;
            end
            ast_pkg::IDX_IRQ_EN:   rd_mux = irq_en_reg;
            ast_pkg::IDX_RX_CTRL: begin
                rd_mux = rx_ctrl_reg;
                rd_mux[3] = 1'b0;
                rd_mux[ast_pkg::RX_FRAMING_ERROR_BIT_BIT] = rx_flag & fifo_head[9]; // [R18]
                rd_mux[ast_pkg::RX_OVERRUN_ERROR_BIT_BIT] = overrun_error_bit_reg;
                rd_mux[ast_pkg::RX_D8_BIT]   = rx_flag & fifo_head[8];
            end
            ast_pkg::IDX_RX_FIFO:  rd_mux = fifo_head[7:0];  // [R14]
            ast_pkg::IDX_TX_CTRL: begin
                rd_mux = tx_ctrl_reg;
                rd_mux[ast_pkg::TX_EMPTY_BIT] = tx_empty;    // [R4]
            end
            ast_pkg::IDX_TX_HOLD:  rd_mux = tx_hold_reg;
            ast_pkg::IDX_BAUD_DIV: rd_mux = baud_div_reg;
            default:               rd_mux = 8'h00;
        endcase
    end

    // Bus pipeline; zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_reg   <= 8'h00;
            wr_reg     <= 1'b0;
            rd_ok_reg  <= 1'b0;
            hrdata_reg <= 32'h0000_0000;
        end else begin
            addr_reg   <= addr_phase ? addr_idx : addr_reg;
            wr_reg     <= addr_phase & hwrite;
            rd_ok_reg  <= addr_phase & ~hwrite;
            hrdata_reg <= (addr_phase & ~hwrite) ? {24'h000000, rd_mux}
                                                 : hrdata_reg;
        end
    end
    assign hrdata    = hrdata_reg;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Software-visible control registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            baud_div_reg <= ast_pkg::BAUD_DIV_RST;
            irq_en_reg   <= ast_pkg::IRQ_EN_RST;
            tx_ctrl_reg  <= 8'h00;
            rx_ctrl_reg  <= 8'h00;
        end else begin
            if (wr_baud) begin
                baud_div_reg <= wdata;
            end
            if (wr_irq_en) begin
                irq_en_reg <= wdata;
            end
            if (wr_tx_ctrl) begin
                tx_ctrl_reg <= {wdata[7:4], 3'b000, wdata[0]};
            end
            if (wr_rx_ctrl) begin
                rx_ctrl_reg <= {wdata[7:4], 4'h0};
            end
        end
    end

    // Holding buffer: a write always wins over the move to the shifter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_hold_reg   <= 8'h00;
            hold_full_reg <= 1'b0;
        end else begin
            tx_hold_reg   <= wr_tx_hold ? wdata : tx_hold_reg;
            hold_full_reg <= wr_tx_hold | (hold_full_reg & ~tx_load); // [R2] [R3]
        end
    end

    // Baud generator and free-running transmit phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            brg_cnt_reg  <= 8'h00;
            tx_phase_reg <= 4'h0;
        end else begin
            brg_cnt_reg  <= x16_tick ? baud_div_reg : brg_cnt_reg - 8'h01;
            tx_phase_reg <= x16_tick ? tx_phase_reg + 4'h1 : tx_phase_reg;
        end
    end

    // Transmitter; a write to an idle shifter loads at the next shift tick
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_busy_reg  <= 1'b0;
            tx_shift_reg <= 10'h3ff;
            tx_left_reg  <= 4'h0;
            tx_out_reg   <= 1'b1;
            tx_oe_reg    <= 1'b0;
        end else begin
            tx_oe_reg <= tx_en | sync_clk_drive;             // [R8] [R22]
            if (!tx_en) begin                                // [R8]
                tx_busy_reg <= 1'b0;
                tx_left_reg <= 4'h0;
                tx_out_reg  <= ~sync_clk_drive | tx_phase_reg[3]; // [R23]
            end else if (tx_load) begin                      // [R6] [R7]
                tx_busy_reg  <= 1'b1;
                tx_out_reg   <= 1'b0;                        // [R25]
                tx_shift_reg <= tx_ctrl_reg[ast_pkg::TX_NINE_BIT] ?
                    {1'b1, tx_ctrl_reg[ast_pkg::TX_D8_BIT], tx_hold_reg} :
                    {2'b11, tx_hold_reg};                    // [R9] [R24]
                tx_left_reg  <= frame_bits(tx_ctrl_reg[ast_pkg::TX_NINE_BIT]);
            end else if (tx_tick & tx_busy_reg) begin
                if (tx_left_reg == 4'h0) begin
                    tx_busy_reg <= 1'b0;
                    tx_out_reg  <= 1'b1;
                end else begin
                    tx_out_reg   <= tx_shift_reg[0];         // [R25]
                    tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
                    tx_left_reg  <= tx_left_reg - 4'h1;
                end
            end
        end
    end
    assign tx_pin_out = tx_out_reg;
    assign tx_pin_oe  = tx_oe_reg;

    // Receive pin synchroniser and edge history
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_sync_reg <= 2'b11;
            rx_prev_reg <= 1'b1;
        end else begin
            rx_sync_reg <= {rx_sync_reg[0], rx_pin_in};
            rx_prev_reg <= rx_sync_reg[1];
        end
    end

    // Receiver; phase restarts on the start edge so votes land mid-bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_state_reg <= ast_pkg::RX_IDLE;
            rx_phase_reg <= 4'h0;
            rx_votes_reg <= 3'b111;
            rx_shift_reg <= 9'h000;
            rx_cnt_reg   <= 4'h0;
        end else if (!rx_en) begin                           // [R11] [R21]
            rx_state_reg <= ast_pkg::RX_IDLE;
            rx_phase_reg <= 4'h0;
        end else begin
            if (x16_tick) begin
                rx_phase_reg <= rx_phase_reg + 4'h1;
                if (rx_phase_reg == ast_pkg::SAMPLE_A ||
                    rx_phase_reg == ast_pkg::SAMPLE_B) begin
                    rx_votes_reg <= {rx_votes_reg[1:0], rx_bit}; // [R19]
                end
            end
            unique case (rx_state_reg)
                ast_pkg::RX_IDLE: begin
                    if (rx_fall) begin                       // [R26]
                        rx_state_reg <= ast_pkg::RX_START;
                        rx_phase_reg <= 4'h0;
                    end
                end
                ast_pkg::RX_START: begin
                    if (rx_vote_at) begin
                        rx_state_reg <= rx_level ? ast_pkg::RX_IDLE
                                                 : ast_pkg::RX_DATA; // [R26]
                        rx_cnt_reg <= frame_bits(
                            rx_ctrl_reg[ast_pkg::RX_NINE_BIT]) - 4'h1;
                    end
                end
                ast_pkg::RX_DATA: begin
                    if (rx_vote_at) begin                    // [R10] [R25]
                        rx_shift_reg <= {rx_level, rx_shift_reg[8:1]};
                        rx_cnt_reg   <= rx_cnt_reg - 4'h1;
                        if (rx_cnt_reg == 4'h1) begin
                            rx_state_reg <= ast_pkg::RX_STOP;
                        end
                    end
                end
                ast_pkg::RX_STOP: begin
                    if (rx_vote_at) begin
                        rx_state_reg <= ast_pkg::RX_IDLE;
                    end
                end
            endcase
        end
    end

    // Overrun: set on a stop bit with a full FIFO, cleared by receive reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overrun_error_bit_reg <= 1'b0;
        end else begin
            overrun_error_bit_reg <= (rx_stop_at & fifo_full & rx_en) |
                        (overrun_error_bit_reg & ~rx_reset);              // [R15] [R16]
        end
    end

    // Receive FIFO; push and pop in one cycle keep the count
    always_ff @(posedge hclk) begin
        if (fifo_push & rx_en) begin
            fifo_mem[fifo_wr_reg] <= rx_word;                // [R14] [R18]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fifo_rd_reg  <= 1'b0;
            fifo_wr_reg  <= 1'b0;
            fifo_cnt_reg <= 2'h0;
        end else begin
            fifo_wr_reg  <= fifo_wr_reg ^ (fifo_push & rx_en);
            fifo_rd_reg  <= fifo_rd_reg ^ fifo_pop;
            fifo_cnt_reg <= fifo_cnt_reg + {1'b0, fifo_push & rx_en}
                            - {1'b0, fifo_pop};              // [R12] [R13]
        end
    end

    // Checks
    sequence s_hold_write;
        wr_tx_hold;
    endsequence

    sequence s_frame_load;
        tx_load ##1 (tx_busy_reg & ~tx_out_reg);
    endsequence

    chk_flag_cleared_by_write: assert property ( // [R3]
        @(posedge hclk) disable iff (!hresetn)
        s_hold_write |=> !tx_flag)
        else $error("transmit flag still set after holding write");

    chk_load_empties_hold: assert property ( // [R2]
        @(posedge hclk) disable iff (!hresetn)
        (tx_load & ~wr_tx_hold) |-> s_frame_load ##0 tx_flag)
        else $error("load did not empty holding buffer or send start");

    chk_no_load_midframe: assert property ( // [R1]
        @(posedge hclk) disable iff (!hresetn)
        (tx_busy_reg & tx_left_reg != 4'h0) |-> !tx_load)
        else $error("shifter reloaded before stop bit");

    chk_abort_floats_pin: assert property ( // [R8]
        @(posedge hclk) disable iff (!hresetn)
        (!tx_en & !sync_clk_drive) |=> (!tx_pin_oe & tx_empty))
        else $error("transmitter not reset on disable");

    chk_tx_empty_status: assert property ( // [R4]
        @(posedge hclk) disable iff (!hresetn)
        (addr_phase & ~hwrite & addr_idx == ast_pkg::IDX_TX_CTRL)
        |=> hrdata[ast_pkg::TX_EMPTY_BIT] == $past(tx_empty))
        else $error("shifter empty status misreported");

    chk_overrun_on_full: assert property ( // [R15]
        @(posedge hclk) disable iff (!hresetn)
        (rx_stop_at & fifo_full & rx_en & ~fifo_pop)
        |=> (overrun_error_bit_reg & fifo_cnt_reg == 2'(FIFO_DEPTH)))
        else $error("overrun not flagged or word stored");

    chk_overrun_blocks: assert property ( // [R16]
        @(posedge hclk) disable iff (!hresetn)
        overrun_error_bit_reg |=> fifo_cnt_reg <= $past(fifo_cnt_reg))
        else $error("FIFO grew while overrun set");

    chk_push_sets_flag: assert property ( // [R12]
        @(posedge hclk) disable iff (!hresetn)
        (fifo_push & rx_en) |=> rx_flag)
        else $error("receive flag not set after transfer");

    chk_rx_off_idle: assert property ( // [R11]
        @(posedge hclk) disable iff (!hresetn)
        !rx_en [*2] |-> rx_state_reg == ast_pkg::RX_IDLE)
        else $error("receiver active while disabled");

    chk_framing_error_bit_queued: assert property ( // [R17]
        @(posedge hclk) disable iff (!hresetn)
        (fifo_push & rx_en & ~rx_level) |=>
        fifo_mem[$past(fifo_wr_reg)][9])
        else $error("framing error not queued");
endmodule : ast_uart

// ===== tb_ast_uart.sv
`timescale 1ns/1ps
module tb_ast_uart;
    logic        hclk;
    logic        hresetn = 1'b0;
    logic        hsel    = 1'b1;
    logic [31:0] haddr   = '0;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [31:0] hwdata  = '0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        tx_out;
    logic        tx_oe;
    logic        rx_line;
    logic        line;
    logic [7:0]  rd;
    int          err_count  = 0;
    int          n_compared = 0;

    // Released transmit pin is pulled up, as an idle line would be
    assign line = tx_oe ? tx_out : 1'b1;

    ast_uart i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .rx_pin_in(rx_line),
        .tx_pin_out(tx_out), .tx_pin_oe(tx_oe)
    );
    ast_remote i_rem (.hclk(hclk), .line_in(line), .line_out(rx_line));

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    task automatic xfer(input logic [7:0] i, input logic wr,
                        input logic [7:0] d);
        htrans <= 2'h2;
        haddr  <= {22'h0, i, 2'h0};
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata[7:0];
    endtask : xfer

    task automatic check(input logic [8:0] g, input logic [8:0] e);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask : check

    task automatic rdchk(input logic [7:0] i, input logic [7:0] e);
        xfer(i, 1'b0, 8'h00);
        check({1'b0, rd}, {1'b0, e});
    endtask : rdchk

    task automatic expect_tx(input logic [8:0] e);
        for (int i = 0; i < 4000 && i_rem.got.size() == 0; i++) begin
            @(posedge hclk);
        end
        if (i_rem.got.size() == 0) begin
            err_count++;
            $display("[ERR] %0t no frame on the transmit line", $time);
        end else begin
            check(i_rem.got.pop_front(), e);
        end
    endtask : expect_tx

    task automatic finish_test();
        if (err_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        finish_test();
    end

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk(ast_pkg::IDX_FLAGS, ast_pkg::FLAGS_RST);
        check({8'h00, hresp}, 9'h000);
        rdchk(ast_pkg::IDX_TX_CTRL, 8'h02);
        rdchk(ast_pkg::IDX_IRQ_EN, ast_pkg::IRQ_EN_RST);
        rdchk(ast_pkg::IDX_BAUD_DIV, ast_pkg::BAUD_DIV_RST);
        xfer(ast_pkg::IDX_IRQ_EN, 1'b1, 8'ha5);
        rdchk(ast_pkg::IDX_IRQ_EN, 8'ha5);
        rdchk(8'h12, 8'h00);
        xfer(ast_pkg::IDX_FLAGS, 1'b1, 8'h00);
        rdchk(ast_pkg::IDX_FLAGS, 8'h02);
        xfer(ast_pkg::IDX_RX_CTRL, 1'b1, 8'h80);
        xfer(ast_pkg::IDX_TX_HOLD, 1'b1, 8'h55);
        repeat (100) @(posedge hclk);
        check(9'(i_rem.got.size()), 9'h000);
        rdchk(ast_pkg::IDX_FLAGS, 8'h00);
        xfer(ast_pkg::IDX_TX_CTRL, 1'b1, 8'h20);
        expect_tx(9'h055);
        xfer(ast_pkg::IDX_TX_HOLD, 1'b1, 8'ha3);
        repeat (40) @(posedge hclk);
        xfer(ast_pkg::IDX_TX_HOLD, 1'b1, 8'h3c);
        rdchk(ast_pkg::IDX_FLAGS, 8'h00);
        rdchk(ast_pkg::IDX_TX_CTRL, 8'h20);
        expect_tx(9'h0a3);
        expect_tx(9'h03c);
        rdchk(ast_pkg::IDX_FLAGS, 8'h02);
        repeat (16) @(posedge hclk);
        i_rem.nine = 1'b1;
        xfer(ast_pkg::IDX_TX_CTRL, 1'b1, 8'h61);
        xfer(ast_pkg::IDX_TX_HOLD, 1'b1, 8'h81);
        expect_tx(9'h181);
        repeat (16) @(posedge hclk);
        i_rem.nine = 1'b0;
        xfer(ast_pkg::IDX_TX_CTRL, 1'b1, 8'h20);
        xfer(ast_pkg::IDX_TX_HOLD, 1'b1, 8'hff);
        repeat (60) @(posedge hclk);
        xfer(ast_pkg::IDX_TX_CTRL, 1'b1, 8'h00);
        repeat (2) @(posedge hclk);
        check({8'h00, tx_oe}, 9'h000);
        rdchk(ast_pkg::IDX_TX_CTRL, 8'h02);
        xfer(ast_pkg::IDX_TX_CTRL, 1'b1, 8'h90);
        repeat (2) @(posedge hclk);
        check({8'h00, tx_oe}, 9'h001);
        xfer(ast_pkg::IDX_TX_CTRL, 1'b1, 8'h00);
        repeat (300) @(posedge hclk);
        i_rem.got.delete();
        i_rem.send(9'h077, 1'b1);
        rdchk(ast_pkg::IDX_FLAGS, 8'h02);
        xfer(ast_pkg::IDX_RX_CTRL, 1'b1, 8'h90);
        i_rem.send(9'h011, 1'b1);
        rdchk(ast_pkg::IDX_FLAGS, 8'h03);
        i_rem.send(9'h022, 1'b1);
        i_rem.send(9'h033, 1'b1);
        rdchk(ast_pkg::IDX_RX_CTRL, 8'h92);
        rdchk(ast_pkg::IDX_RX_FIFO, 8'h11);
        rdchk(ast_pkg::IDX_RX_FIFO, 8'h22);
        rdchk(ast_pkg::IDX_FLAGS, 8'h02);
        i_rem.send(9'h055, 1'b1);
        rdchk(ast_pkg::IDX_FLAGS, 8'h02);
        xfer(ast_pkg::IDX_RX_CTRL, 1'b1, 8'h80);
        xfer(ast_pkg::IDX_RX_CTRL, 1'b1, 8'h90);
        rdchk(ast_pkg::IDX_RX_CTRL, 8'h90);
        i_rem.glitch();
        repeat (40) @(posedge hclk);
        rdchk(ast_pkg::IDX_FLAGS, 8'h02);
        i_rem.send(9'h044, 1'b0);
        rdchk(ast_pkg::IDX_RX_CTRL, 8'h94);
        rdchk(ast_pkg::IDX_RX_FIFO, 8'h44);
        xfer(ast_pkg::IDX_RX_CTRL, 1'b1, 8'hd0);
        i_rem.nine = 1'b1;
        i_rem.send(9'h1a5, 1'b1);
        rdchk(ast_pkg::IDX_RX_CTRL, 8'hd1);
        rdchk(ast_pkg::IDX_RX_FIFO, 8'ha5);
        finish_test();
    end
endmodule : tb_ast_uart
